/* rtl/tcp_bridge.sv */
/*
 transceiver config pass-through bridge: takes ascii-hex frames from a host
 terminal and shifts the five control words into the transceiver.
 assumes the transceiver latches a word on the rising strobe after 24 bits,
 msb first, data sampled on the rising programming clock.
*/
`timescale 1ns/1ps
// How it works
// - five transceiver words loaded over programming port
// - host link 38400 baud 8n1 no handshake
// - each word is six ascii hex characters
// - frame opens with asterisk, closes with return
// - words arrive a, b, c, d, e
// - word a sets mode 0, b mode 1
// - antenna enables follow the mode line only
// - word a field layout, low field first
module tcp_bridge
    import tcp_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic host_rxd_in,
    input wire logic mode_sel_in,
    output logic prog_clk_out,
    output logic prog_data_out,
    output logic prog_strobe_out,
    output logic mode_line_out,
    output logic tx_path_en_out,
    output logic rx_path_en_out,
    output logic busy_out,
    output logic frame_drop_out,
    output logic [WORD_BITS-1:0] synth_mode0_word_out
);
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_err;
    tcp_parse_t pstate_ff;
    logic [5:0] nib_cnt_ff;
    logic [4*HEX_PER_FRAME-1:0] frame_ff;
    logic [4*HEX_PER_FRAME-1:0] load_ff;
    logic go_ff;
    tcp_spi_t sstate_ff;
    logic [2:0] word_idx_ff;
    logic [4:0] bit_idx_ff;
    logic [7:0] half_ff;
    logic [WORD_BITS-1:0] word_sh_ff;
    logic [2:0] mode_sync_ff;
    logic mode_ff;

    ////////////////////////////////////////////////////////////////////////////
    tcp_uart_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .rxd_in(host_rxd_in),
        .byte_out(rx_byte),
        .valid_out(rx_valid),
        .frame_err_out(rx_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // hex decode
    wire is_dig = (rx_byte >= 8'h30) && (rx_byte <= 8'h39);
    wire is_up = (rx_byte >= 8'h41) && (rx_byte <= 8'h46);
    wire is_lo = (rx_byte >= 8'h61) && (rx_byte <= 8'h66);
    wire is_hex = is_dig || is_up || is_lo;
    wire [7:0] nib_wide = is_dig ? rx_byte - 8'h30 : (is_up ? rx_byte - 8'h37 : rx_byte - 8'h57);
    wire [3:0] nib = nib_wide[3:0];
    wire is_start = (rx_byte == FRAME_START);
    wire is_end = (rx_byte == FRAME_END);
    wire count_ok = (nib_cnt_ff == 6'(HEX_PER_FRAME));
    wire spi_idle = (sstate_ff == TCP_S_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // frame parser; characters beyond the frame length are counted as errors
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pstate_ff <= TCP_P_IDLE;
            nib_cnt_ff <= 6'h00;
            frame_ff <= '0;
            load_ff <= '0;
            go_ff <= 1'b0;
            frame_drop_out <= 1'b0;
        end else begin
            go_ff <= 1'b0;
            frame_drop_out <= 1'b0;
            if (rx_err && pstate_ff == TCP_P_FRAME) begin
                pstate_ff <= TCP_P_IDLE;
                frame_drop_out <= 1'b1;
            end else if (rx_valid) begin
                case (pstate_ff)
                    TCP_P_IDLE: begin
                        if (is_start) begin
                            pstate_ff <= TCP_P_FRAME;
                            nib_cnt_ff <= 6'h00;
                        end
                    end
                    TCP_P_WAIT: begin
                        // bad frame: wait for a fresh start character
                        if (is_start) begin
                            pstate_ff <= TCP_P_FRAME;
                            nib_cnt_ff <= 6'h00;
                        end
                    end
                    TCP_P_FRAME: begin
                        if (is_end) begin
                            pstate_ff <= TCP_P_IDLE;
                            // a frame that lands while shifting is dropped, not queued
                            if (count_ok && spi_idle) begin
                                load_ff <= frame_ff;
                                go_ff <= 1'b1;
                            end else begin
                                frame_drop_out <= 1'b1;
                            end
                        end else if (is_start) begin
                            nib_cnt_ff <= 6'h00;
                            frame_drop_out <= 1'b1;
                        end else if (is_hex && !count_ok) begin
                            frame_ff <= {frame_ff[4*HEX_PER_FRAME-5:0], nib};
                            nib_cnt_ff <= nib_cnt_ff + 6'h01;
                        end else begin
                            pstate_ff <= TCP_P_WAIT;
                            frame_drop_out <= 1'b1;
                        end
                    end
                    default: pstate_ff <= TCP_P_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programming port shifter; word a sits at the top of the frame
    wire [WORD_BITS-1:0] cur_word = load_ff[(NUM_REGS-1-word_idx_ff)*WORD_BITS +: WORD_BITS];
    wire half_done = (half_ff == 8'h00);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sstate_ff <= TCP_S_IDLE;
            word_idx_ff <= 3'h0;
            bit_idx_ff <= 5'h00;
            half_ff <= 8'h00;
            word_sh_ff <= WORD_RESET;
            prog_clk_out <= 1'b0;
            prog_data_out <= 1'b0;
            prog_strobe_out <= 1'b0;
            busy_out <= 1'b0;
            synth_mode0_word_out <= WORD_RESET;
        end else begin
            if (!half_done) begin
                half_ff <= half_ff - 8'h01;
            end
            busy_out <= !spi_idle || go_ff;
            case (sstate_ff)
                TCP_S_IDLE: begin
                    if (go_ff) begin
                        word_idx_ff <= 3'h0;
                        sstate_ff <= TCP_S_LOAD;
                    end
                end
                TCP_S_LOAD: begin
                    word_sh_ff <= cur_word;
                    bit_idx_ff <= 5'h00;
                    if (word_idx_ff == 3'h0) begin
                        synth_mode0_word_out <= cur_word;
                    end
                    half_ff <= 8'(SPI_HALF_CYC - 1);
                    sstate_ff <= TCP_S_LOW;
                end
                TCP_S_LOW: begin
                    prog_clk_out <= 1'b0;
                    prog_data_out <= word_sh_ff[WORD_BITS-1];
                    if (half_done) begin
                        half_ff <= 8'(SPI_HALF_CYC - 1);
                        sstate_ff <= TCP_S_HIGH;
                    end
                end
                TCP_S_HIGH: begin
                    prog_clk_out <= 1'b1;
                    if (half_done) begin
                        half_ff <= 8'(SPI_HALF_CYC - 1);
                        word_sh_ff <= {word_sh_ff[WORD_BITS-2:0], 1'b0};
                        bit_idx_ff <= bit_idx_ff + 5'h01;
                        sstate_ff <= (bit_idx_ff == 5'(WORD_BITS - 1)) ? TCP_S_LATCH : TCP_S_LOW;
                    end
                end
                TCP_S_LATCH: begin
                    prog_clk_out <= 1'b0;
                    prog_strobe_out <= 1'b1;
                    if (half_done) begin
                        half_ff <= 8'(SPI_HALF_CYC - 1);
                        sstate_ff <= TCP_S_NEXT;
                    end
                end
                TCP_S_NEXT: begin
                    // one word completes before the next begins
                    prog_strobe_out <= 1'b0;
                    if (half_done) begin
                        word_idx_ff <= word_idx_ff + 3'h1;
                        sstate_ff <= (word_idx_ff == 3'(NUM_REGS - 1)) ? TCP_S_IDLE : TCP_S_LOAD;
                    end
                end
                default: sstate_ff <= TCP_S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode line from the board; switch enables take nothing else
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_sync_ff <= 3'h0;
            mode_ff <= 1'b0;
            mode_line_out <= 1'b0;
            tx_path_en_out <= 1'b1;
            rx_path_en_out <= 1'b0;
        end else begin
            mode_sync_ff <= {mode_sync_ff[1:0], mode_sel_in};
            if (mode_sync_ff[1] == mode_sync_ff[2]) begin
                mode_ff <= mode_sync_ff[2];
            end
            mode_line_out <= mode_ff;
            tx_path_en_out <= !mode_ff;
            rx_path_en_out <= mode_ff;
        end
    end
endmodule : tcp_bridge

/* rtl/tcp_pkg.sv */
/*
 package for the transceiver config pass-through bridge: framing characters,
 serial link timing, word layout and programming port timing.
 assumes a single 125 mhz system clock.
*/
package tcp_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int BAUD_BPS = 38400;
    localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
    localparam int HALF_BIT_CYC = BIT_CYC / 2;
    localparam int DATA_BITS = 8;
    localparam int NUM_REGS = 5;
    localparam int WORD_BITS = 24;
    localparam int HEX_PER_WORD = WORD_BITS / 4;
    localparam int HEX_PER_FRAME = NUM_REGS * HEX_PER_WORD;
    localparam logic [7:0] FRAME_START = 8'h2a;
    localparam logic [7:0] FRAME_END = 8'h0d;
    localparam int SPI_HALF_NS = 100;
    // scaled to mhz first so the product stays inside 32 bits
    localparam int SPI_HALF_CYC = (SPI_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // register a word fields, from the low end
    localparam int BAND_SELECT_LSB = 0;
    localparam int PUMP_CURRENT_LSB = 2;
    localparam int AUX_SINGLE_BIT_LSB = 4;
    localparam int DIRECTION_MODE0_LSB = 5;
    localparam int POWER_ATTEN_MODE0_LSB = 6;
    localparam int MAIN_B_DIVIDER_LSB = 8;
    localparam int MAIN_A_DIVIDER_LSB = 17;
    localparam int REG_ADDR_LSB = 22;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h000000;
    typedef enum logic [1:0] {TCP_RX_IDLE, TCP_RX_START, TCP_RX_DATA, TCP_RX_STOP} tcp_rx_t;
    typedef enum logic [1:0] {TCP_P_IDLE, TCP_P_WAIT, TCP_P_FRAME} tcp_parse_t;
    typedef enum logic [2:0] {
        TCP_S_IDLE, TCP_S_LOAD, TCP_S_LOW, TCP_S_HIGH, TCP_S_LATCH, TCP_S_NEXT
    } tcp_spi_t;
endpackage : tcp_pkg

/* rtl/tcp_uart_rx.sv */
/*
 asynchronous serial receiver, 8 data bits, no parity, one stop bit.
 assumes the line idles high and arrives from outside the clock domain.
*/
`timescale 1ns/1ps
module tcp_uart_rx
    import tcp_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic rxd_in,
    output logic [7:0] byte_out,
    output logic valid_out,
    output logic frame_err_out
);
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    logic [2:0] sync_ff;
    logic line;
    logic line_ff;
    tcp_rx_t state_ff;
    logic [15:0] cnt_ff;
    logic [2:0] bit_ff;
    logic [7:0] shift_ff;
    wire cnt_done = (cnt_ff == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // three stage sync; a change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_ff <= 3'h7;
            line_ff <= 1'b1;
        end else begin
            sync_ff <= {sync_ff[1:0], rxd_in};
            if (sync_ff[1] == sync_ff[2]) begin
                line_ff <= sync_ff[2];
            end
        end
    end
    assign line = line_ff;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= TCP_RX_IDLE;
            cnt_ff <= 16'h0000;
            bit_ff <= 3'h0;
            shift_ff <= 8'h00;
            byte_out <= 8'h00;
            valid_out <= 1'b0;
            frame_err_out <= 1'b0;
        end else begin
            valid_out <= 1'b0;
            frame_err_out <= 1'b0;
            if (!cnt_done) begin
                cnt_ff <= cnt_ff - 16'h0001;
            end
            case (state_ff)
                TCP_RX_IDLE: begin
                    if (!line) begin
                        state_ff <= TCP_RX_START;
                        cnt_ff <= 16'(HALF_CYCLES - 1);
                    end
                end
                TCP_RX_START: begin
                    if (cnt_done) begin
                        // glitch shorter than half a bit is not a start
                        state_ff <= line ? TCP_RX_IDLE : TCP_RX_DATA;
                        cnt_ff <= 16'(BIT_CYCLES - 1);
                        bit_ff <= 3'h0;
                    end
                end
                TCP_RX_DATA: begin
                    if (cnt_done) begin
                        shift_ff <= {line, shift_ff[7:1]};
                        cnt_ff <= 16'(BIT_CYCLES - 1);
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'(DATA_BITS - 1)) begin
                            state_ff <= TCP_RX_STOP;
                        end
                    end
                end
                TCP_RX_STOP: begin
                    if (cnt_done) begin
                        state_ff <= TCP_RX_IDLE;
                        byte_out <= shift_ff;
                        valid_out <= line;
                        frame_err_out <= !line;
                    end
                end
                default: state_ff <= TCP_RX_IDLE;
            endcase
        end
    end
endmodule : tcp_uart_rx

/* test/tb_top.sv */
/*
 self-checking bench for the config bridge: mode rows, one noisy byte
 stream with four bad frames and one good one, then a mid-run reset.
 assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
    import tcp_pkg::*;
;
    typedef struct {logic sel; logic line; logic tx; logic rx;} tcp_mode_row_t;
    // short host bit time keeps the run small; the design default is the real rate
    localparam int TB_BIT_CYC = 32;
    logic clk_in, resetn_in, mode_sel_in, host_rxd;
    logic prog_clk, prog_data, prog_strobe, mode_line, tx_en, rx_en, busy, drop;
    logic [WORD_BITS-1:0] word_a;
    logic [23:0] sh, exp_w[5], got_q[$];
    logic [7:0] q[$];
    logic pclk_q, strb_q;
    int num_errors, n_checks, drops;
    tcp_mode_row_t rows[3] = '{'{1'b0, 1'b0, 1'b1, 1'b0}, '{1'b1, 1'b1, 1'b0, 1'b1},
        '{1'b0, 1'b0, 1'b1, 1'b0}};
    tcp_host_term #(.BIT_CYCLES(TB_BIT_CYC)) host (.clk_in(clk_in), .txd_out(host_rxd));
    tcp_bridge #(.BIT_CYCLES(TB_BIT_CYC)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
        .host_rxd_in(host_rxd),
        .mode_sel_in(mode_sel_in), .prog_clk_out(prog_clk), .prog_data_out(prog_data),
        .prog_strobe_out(prog_strobe), .mode_line_out(mode_line), .tx_path_en_out(tx_en),
        .rx_path_en_out(rx_en), .busy_out(busy), .frame_drop_out(drop),
        .synth_mode0_word_out(word_a));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // capture what the transceiver would latch, one word per strobe; falling edge, settled
    always @(negedge clk_in) begin
        if (prog_clk && !pclk_q) sh = {sh[22:0], prog_data};
        if (prog_strobe && !strb_q) got_q.push_back(sh);
        if (drop) drops++;
        pclk_q = prog_clk;
        strb_q = prog_strobe;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] hexc(input logic [3:0] n, input bit lc);
        if (n < 4'ha) return 8'h30 + 8'(n);
        return (lc ? 8'h57 : 8'h37) + 8'(n);
    endfunction : hexc
    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn_in = 1'b0;
        mode_sel_in = 1'b0;
        pclk_q = 1'b0;
        strb_q = 1'b0;
        repeat (5) @(negedge clk_in);
        chk({19'h0, busy, drop, prog_clk, prog_strobe, tx_en}, 24'h000001);
        chk(word_a, WORD_RESET);
        resetn_in = 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            mode_sel_in = rows[i].sel;
            repeat (10) @(negedge clk_in);
            chk({21'h0, mode_line, tx_en, rx_en}, {21'h0, rows[i].line, rows[i].tx, rows[i].rx});
        end
        $display("mode rows done");
        // transmit in mode 0, so word a carries direction 0 and band select 1
        exp_w[0] = (24'h000001 << BAND_SELECT_LSB) | (24'h000001 << PUMP_CURRENT_LSB) |
            (24'h0001b3 << MAIN_B_DIVIDER_LSB) | (24'h00000a << MAIN_A_DIVIDER_LSB);
        exp_w[1] = 24'h5a3c01;
        exp_w[2] = 24'h000030;
        exp_w[3] = 24'hc0ffee;
        exp_w[4] = 24'hbeef42;
        // bad char, short count, restart inside a frame, then a good frame
        q = '{FRAME_START, 8'h31, 8'h67, FRAME_START, 8'h31, FRAME_END, FRAME_START,
            8'h35, FRAME_START};
        for (int w = 0; w < 5; w++) begin
            for (int k = 5; k >= 0; k--) q.push_back(hexc(exp_w[w][4*k+:4], w == 4));
        end
        q.push_back(FRAME_END);
        host.send_byte(FRAME_START, 1'b1);
        host.send_byte(8'hff, 1'b0);
        foreach (q[i]) host.send_byte(q[i], 1'b1);
        chk({23'h0, busy}, 24'h000001);
        for (int n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge clk_in);
        if (busy !== 1'b0) begin
            chk({23'h0, busy}, 24'h000000);
            give_verdict();
        end
        chk(24'(drops), 24'h000004);
        chk(24'(got_q.size()), 24'h000005);
        foreach (got_q[i]) chk(got_q[i], exp_w[i]);
        chk(word_a, exp_w[0]);
        $display("frame stream test done");
        resetn_in = 1'b0;
        @(negedge clk_in);
        chk({22'h0, tx_en, busy}, 24'h000002);
        chk(word_a, WORD_RESET);
        resetn_in = 1'b1;
        repeat (2) @(negedge clk_in);
        chk({21'h0, busy, prog_clk, drop}, 24'h000000);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule : tb_top

/* test/tcp_bridge_chk.sv */
/*
 checker for the config bridge: watches only the top module ports.
 assumes one clock and an async active-low reset; bound at the foot.
*/
`timescale 1ns/1ps
module tcp_bridge_chk
    import tcp_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic host_rxd_in,
    input wire logic mode_sel_in,
    input wire logic prog_clk_out,
    input wire logic prog_data_out,
    input wire logic prog_strobe_out,
    input wire logic mode_line_out,
    input wire logic tx_path_en_out,
    input wire logic rx_path_en_out,
    input wire logic busy_out,
    input wire logic frame_drop_out,
    input wire logic [WORD_BITS-1:0] synth_mode0_word_out
);
    ////////////////////////////////////////////////////////////////////////
    // rising programming clocks seen since the last strobe
    logic clk_prev_ff;
    logic [4:0] bit_cnt_ff;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clk_prev_ff <= 1'b0;
            bit_cnt_ff <= 5'h00;
        end else begin
            clk_prev_ff <= prog_clk_out;
            if (prog_strobe_out) begin
                bit_cnt_ff <= 5'h00;
            end else if (prog_clk_out && !clk_prev_ff) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_strobe_hold;
        prog_strobe_out [*8];
    endsequence
    // eight quiet samples leave room for the input synchroniser
    sequence s_mode_settled;
        $stable(mode_sel_in) [*8];
    endsequence
    a_strobe_len: assert property ($rose(prog_strobe_out) |-> s_strobe_hold)
        else $error("strobe pulse too short");
    a_word_bits: assert property ($rose(prog_strobe_out) |-> bit_cnt_ff == 5'h18)
        else $error("word not 24 bits before strobe");
    a_mode_follow: assert property (s_mode_settled |->
        mode_line_out == mode_sel_in && rx_path_en_out == mode_sel_in)
        else $error("mode outputs do not follow mode input");
    a_path_split: assert property (tx_path_en_out != rx_path_en_out)
        else $error("switch enables not complementary");
    a_drop_once: assert property (frame_drop_out |=> !frame_drop_out)
        else $error("drop pulse longer than one cycle");
    a_drop_idle: assert property (frame_drop_out && !busy_out |=> !busy_out)
        else $error("dropped frame started shifting");
    a_strobe_noclk: assert property (prog_strobe_out |-> !prog_clk_out)
        else $error("clock high during strobe");
    a_data_hold: assert property (prog_clk_out && $past(prog_clk_out) |->
        $stable(prog_data_out)) else $error("data moved while clock high");
    a_idle_port: assert property (!busy_out && !$past(busy_out) |->
        !prog_clk_out && !prog_strobe_out) else $error("port active while idle");
endmodule : tcp_bridge_chk
bind tcp_bridge tcp_bridge_chk chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .host_rxd_in(host_rxd_in), .mode_sel_in(mode_sel_in), .prog_clk_out(prog_clk_out),
    .prog_data_out(prog_data_out), .prog_strobe_out(prog_strobe_out),
    .mode_line_out(mode_line_out), .tx_path_en_out(tx_path_en_out),
    .rx_path_en_out(rx_path_en_out), .busy_out(busy_out), .frame_drop_out(frame_drop_out),
    .synth_mode0_word_out(synth_mode0_word_out));

/* test/tcp_host_term.sv */
/*
 host terminal model: sends bytes on the serial line, 8n1, lsb first.
 assumes the bench clock; the line idles at the mark level.
*/
`timescale 1ns/1ps
module tcp_host_term
    import tcp_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
)
(
    input wire logic clk_in,
    output logic txd_out
);
    initial txd_out = 1'b1;
    // no handshake lines: bytes go out back to back, whole bit times only
    // a low stop bit makes a framing error; the line then idles for ten bit times
    task automatic send_byte(input logic [7:0] b, input logic stop_bit);
        logic [9:0] f;
        f = {stop_bit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_in);
            txd_out = f[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_in);
        end
        if (!stop_bit) begin
            @(negedge clk_in);
            txd_out = 1'b1;
            repeat (10 * BIT_CYCLES) @(negedge clk_in);
        end
    endtask : send_byte
endmodule : tcp_host_term
